// ---- logic/pcr_pkg.sv ----
// Package for the protection configuration register and restart sequencer.
// Assumes a single 200 MHz clock and an active-low asynchronous reset.
package pcr_pkg;

    // ------------------------------------------------------------------
    // Register layout
    // ------------------------------------------------------------------
    localparam logic [7:0] PCR_CFG_RESET    = 8'h43;
    localparam int         PCR_BIT_TRK_EN   = 7;
    localparam int         PCR_BIT_PH_EN    = 6;
    localparam int         PCR_BIT_TRL      = 5;
    localparam int         PCR_BIT_OTL      = 4;
    localparam int         PCR_BIT_OCL      = 3;
    localparam int         PCR_BIT_UVL      = 2;
    localparam int         PCR_BIT_OVL      = 1;
    localparam int         PCR_BIT_PVL      = 0;

    // Fault vector positions, shared by the fault inputs and status bits.
    localparam int         PCR_F_PV         = 0;
    localparam int         PCR_F_OV         = 1;
    localparam int         PCR_F_UV         = 2;
    localparam int         PCR_F_OC         = 3;
    localparam int         PCR_F_OT         = 4;
    localparam int         PCR_F_TR         = 5;
    localparam int         PCR_NFAULT       = 6;
    localparam logic [5:0] PCR_STATUS_RESET = 6'h3f;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int         PCR_CLK_MHZ      = 200;
    localparam int         PCR_RETRY_MS     = 130;
    localparam int         PCR_RETRY_CYC    = PCR_RETRY_MS * 1000 * PCR_CLK_MHZ;
    localparam int         PCR_CNT_W        = 25;

    typedef enum logic [2:0] {
        PCR_OFF,
        PCR_RAMP_UP,
        PCR_ON,
        PCR_RAMP_DOWN,
        PCR_WAIT
    } pcr_state_t;

endpackage : pcr_pkg

// ---- logic/pcr_protect.sv ----
// Protection configuration register with the fault-recovery sequencer.
// Assumes fault inputs are synchronous levels and the ramp engine reports done.
module pcr_protect
    import pcr_pkg::*;
#(
    parameter int RETRY_CYC = PCR_RETRY_CYC
)
(
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    // Register port from the I2C front end
    input  wire logic                  cfg_we,
    input  wire logic [7:0]            cfg_wdata,
    input  wire logic                  status_clr,
    input  wire logic [PCR_NFAULT-1:0] status_clr_mask,
    // Converter command and fault conditions
    input  wire logic                  turn_on,
    input  wire logic [PCR_NFAULT-1:0] fault_in,
    input  wire logic                  ramp_done,
    // Register and state view
    output logic [7:0]                 protection_config,
    output logic [PCR_NFAULT-1:0]      fault_status_register,
    // Power stage control
    output logic                       output_enable,
    output logic                       ramp_up,
    output logic                       ramp_down,
    output logic                       high_side_off,
    output logic                       low_side_on,
    output logic                       retry_pulse
);

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    // The host may rewrite the register at any time; new selects apply to the next trip.
    logic [7:0] cfg_r;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            cfg_r <= PCR_CFG_RESET;
        else if (cfg_we)
            cfg_r <= cfg_wdata;
    end

    assign protection_config = cfg_r;

    // Latch selection per fault position, taken from the register.
    function automatic logic [PCR_NFAULT-1:0] latch_sel(input logic [7:0] c);
        latch_sel             = '0;
        latch_sel[PCR_F_PV]   = c[PCR_BIT_PVL];
        latch_sel[PCR_F_OV]   = c[PCR_BIT_OVL];
        latch_sel[PCR_F_UV]   = c[PCR_BIT_UVL];
        latch_sel[PCR_F_OC]   = c[PCR_BIT_OCL];
        latch_sel[PCR_F_OT]   = c[PCR_BIT_OTL];
        latch_sel[PCR_F_TR]   = c[PCR_BIT_TRL];
    endfunction

    // ------------------------------------------------------------------
    // Fault qualification
    // ------------------------------------------------------------------
    pcr_state_t                state_r;
    logic [PCR_NFAULT-1:0]     active;
    logic [PCR_NFAULT-1:0]     lsel;
    logic                      trip;
    logic                      soft_trip;
    logic                      ov_trip;
    logic                      any_fault;
    logic [PCR_NFAULT-1:0]     latch_hit;

    always_comb
    begin
        active           = fault_in;
        // Tracking is only checked while ramping up.
        active[PCR_F_TR] = fault_in[PCR_F_TR] & cfg_r[PCR_BIT_TRK_EN]
                         & (state_r == PCR_RAMP_UP);
        active[PCR_F_PV] = fault_in[PCR_F_PV] & cfg_r[PCR_BIT_PH_EN];
    end

    assign lsel      = latch_sel(cfg_r);
    assign latch_hit = active & lsel;
    assign any_fault = |active;
    assign trip      = any_fault && (state_r == PCR_RAMP_UP || state_r == PCR_ON);
    // Undervoltage and overtemperature are soft faults that ramp down; overcurrent and
    // tracking shut off fast; overvoltage and phase errors also crowbar the output.
    // Soft faults ramp down even when a fast one trips with them; errors act at once.
    assign soft_trip = active[PCR_F_UV] | active[PCR_F_OT];
    assign ov_trip   = active[PCR_F_OV] | active[PCR_F_PV];

    // ------------------------------------------------------------------
    // Status register, a 0 marks a tripped protection
    // ------------------------------------------------------------------
    // The host sets a bit back to 1 through the clear mask once it has seen the trip.
    logic [PCR_NFAULT-1:0] status_r;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            status_r <= PCR_STATUS_RESET;
        else if (trip)
            // A trip in the clear cycle still wins.
            status_r <= (status_r | (status_clr ? status_clr_mask : '0)) & ~active;
        else if (status_clr)
            status_r <= status_r | status_clr_mask;
    end

    assign fault_status_register = status_r;

    // ------------------------------------------------------------------
    // Latch memory and turn-on edge
    // ------------------------------------------------------------------
    // A latched bit is released once the host clear shows as a 1 in the status bit,
    // or at once when the turn-on command drops; reset is the power-cycle release.
    logic [PCR_NFAULT-1:0] latched_r;
    logic                  turn_on_d_r;
    logic                  turn_on_rise;

    assign turn_on_rise = turn_on & ~turn_on_d_r;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            turn_on_d_r <= 1'b0;
        else
            turn_on_d_r <= turn_on;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            latched_r <= '0;
        else if (trip)
            latched_r <= latched_r | latch_hit;
        else if (!turn_on)
            latched_r <= '0;
        else
            latched_r <= latched_r & ~status_r;
    end

    // ------------------------------------------------------------------
    // Restart timer
    // ------------------------------------------------------------------
    // The interval keeps counting while a fault persists and reloads only if it runs out with the fault still present,
    // so a retry can start less than one full interval after the condition was last seen.
    logic [PCR_CNT_W-1:0] cnt_r;
    logic                 timer_done;

    assign timer_done = (cnt_r == '0);

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            cnt_r <= '0;
        else if (trip)
            cnt_r <= PCR_CNT_W'(RETRY_CYC - 1);
        else if (state_r == PCR_WAIT && !timer_done)
            cnt_r <= cnt_r - 1'b1;
        else if (state_r == PCR_WAIT && any_fault)
            cnt_r <= PCR_CNT_W'(RETRY_CYC - 1);
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // A restart needs the interval run out, no fault standing, no latch held and
    // the turn-on command still high.
    logic release_ok;
    assign release_ok = timer_done && !any_fault && (latched_r == '0) && turn_on;

    // Fast and error shutdowns skip the ramp-down and wait with the high side off unless turn_on drops with the trip; error shutdowns keep the low side on.

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            state_r <= PCR_OFF;
        else
            case (state_r)
                PCR_OFF:
                    if (turn_on_rise && !any_fault)
                        state_r <= PCR_RAMP_UP;
                PCR_RAMP_UP, PCR_ON:
                    if (!turn_on)
                        state_r <= PCR_RAMP_DOWN;
                    else if (trip)
                        state_r <= soft_trip && !ov_trip ? PCR_RAMP_DOWN : PCR_WAIT;
                    else if (state_r == PCR_RAMP_UP && ramp_done)
                        state_r <= PCR_ON;
                PCR_RAMP_DOWN:
                    if (ramp_done)
                        state_r <= (turn_on ? PCR_WAIT : PCR_OFF);
                PCR_WAIT:
                    if (!turn_on)
                        state_r <= PCR_OFF;
                    else if (release_ok)
                        state_r <= PCR_RAMP_UP;
                default:
                    state_r <= PCR_OFF;
            endcase
    end

    // ------------------------------------------------------------------
    // Output stage, all registered
    // ------------------------------------------------------------------
    // Registering every output keeps decode glitches away from the power stage.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            output_enable <= 1'b0;
            ramp_up       <= 1'b0;
            ramp_down     <= 1'b0;
            high_side_off <= 1'b1;
            low_side_on   <= 1'b0;
            retry_pulse   <= 1'b0;
        end
        else
        begin
            output_enable <= (state_r == PCR_RAMP_UP || state_r == PCR_ON || state_r == PCR_RAMP_DOWN)
                             && !(trip && !soft_trip) || (trip && soft_trip && !ov_trip);
            ramp_up       <= (state_r == PCR_RAMP_UP) && !trip;
            ramp_down     <= (state_r == PCR_RAMP_DOWN) || (trip && soft_trip && !ov_trip);
            high_side_off <= (state_r == PCR_OFF || state_r == PCR_WAIT) || (trip && !(soft_trip && !ov_trip));
            low_side_on   <= trip ? ov_trip : (low_side_on && state_r == PCR_WAIT);
            retry_pulse   <= (state_r == PCR_WAIT) && release_ok;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Register contents after reset and after a host write.
    reset_value_a: assert property (@(posedge clock)
        $rose(reset_n) |-> cfg_r == PCR_CFG_RESET)
        else $error("config reset value wrong");
    cfg_write_a: assert property (@(posedge clock) disable iff (!reset_n)
        cfg_we |=> cfg_r == $past(cfg_wdata))
        else $error("config write lost");

    // Detection gates; a disabled check must never reach the trip logic.
    phase_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
        (!cfg_r[PCR_BIT_PH_EN] |-> !active[PCR_F_PV]))
        else $error("phase error not gated by enable");
    track_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
        ((!cfg_r[PCR_BIT_TRK_EN] || state_r != PCR_RAMP_UP) |-> !active[PCR_F_TR]))
        else $error("tracking fault not gated by enable");

    // Shutdown actions, one for each severity class.
    status_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
        trip |=> ((status_r & $past(active)) == '0))
        else $error("status bit not cleared on trip");
    ov_switch_a: assert property (@(posedge clock) disable iff (!reset_n)
        (trip && ov_trip) |=> (low_side_on && high_side_off))
        else $error("overvoltage switch action wrong");
    soft_down_a: assert property (@(posedge clock) disable iff (!reset_n)
        (trip && soft_trip && !ov_trip) |=> (ramp_down && output_enable))
        else $error("soft shutdown did not ramp");
    fast_off_a: assert property (@(posedge clock) disable iff (!reset_n)
        (trip && !soft_trip && !ov_trip) |=> (high_side_off && !low_side_on && !output_enable))
        else $error("fast turn-off wrong");

    // Recovery: latch memory, interval and restart.
    latch_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
        trip |=> ((latched_r & $past(latch_hit)) == $past(latch_hit)))
        else $error("latching trip not remembered");
    latch_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        (state_r == PCR_WAIT && latched_r != '0) |=> state_r != PCR_RAMP_UP)
        else $error("latched fault restarted");
    release_turn_a: assert property (@(posedge clock) disable iff (!reset_n)
        (!turn_on && !trip) |=> (latched_r == '0))
        else $error("turn-off did not release latch");
    timer_load_a: assert property (@(posedge clock) disable iff (!reset_n)
        trip |=> (cnt_r == PCR_CNT_W'(RETRY_CYC - 1)))
        else $error("restart interval not loaded");
    retry_wait_a: assert property (@(posedge clock) disable iff (!reset_n)
        (state_r == PCR_WAIT && !timer_done) |=> state_r != PCR_RAMP_UP)
        else $error("restart before interval");
    restart_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
        (state_r == PCR_WAIT && release_ok) |=> (state_r == PCR_RAMP_UP && retry_pulse))
        else $error("restart not taken");
    ramp_start_a: assert property (@(posedge clock) disable iff (!reset_n)
        (state_r == PCR_RAMP_UP && !trip) |=> ramp_up)
        else $error("restart did not ramp");

    // Main scenarios worth seeing in every run.
    retry_c: cover property (@(posedge clock) disable iff (!reset_n) retry_pulse);
    ov_c: cover property (@(posedge clock) disable iff (!reset_n) trip && ov_trip);
    latch_c: cover property (@(posedge clock) disable iff (!reset_n) trip && latch_hit != '0);
    soft_c: cover property (@(posedge clock) disable iff (!reset_n) trip && soft_trip && !ov_trip);
    toggle_c: cover property (@(posedge clock) disable iff (!reset_n) state_r == PCR_WAIT && !turn_on);

endmodule // pcr_protect

// ---- verification/pcr_host_model.sv ----
// Host power manager model: writes the configuration register and clears status.
// Assumes the register port of pcr_protect, driven just after the rising edge.
module pcr_host_model
    import pcr_pkg::*;
(
    // Clock
    input  wire logic                  clock,
    // Register port toward the block
    output logic                       cfg_we,
    output logic [7:0]                 cfg_wdata,
    output logic                       status_clr,
    output logic [PCR_NFAULT-1:0]      status_clr_mask
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        cfg_we = 1'b0;
        cfg_wdata = 8'h00;
        status_clr = 1'b0;
        status_clr_mask = '0;
    end

    // Released lines show the inverse so stale data is never mistaken for new.
    task automatic write_cfg(input logic [7:0] v);
        @(posedge clock);
        cfg_we <= 1'b1;
        cfg_wdata <= v;
        @(posedge clock);
        cfg_we <= 1'b0;
        cfg_wdata <= ~v;
    endtask

    task automatic clear_status(input logic [PCR_NFAULT-1:0] m);
        @(posedge clock);
        status_clr <= 1'b1;
        status_clr_mask <= m;
        @(posedge clock);
        status_clr <= 1'b0;
        status_clr_mask <= ~m;
    endtask
endmodule // pcr_host_model

// ---- verification/protection_config_restart_test.sv ----
// Self-checking bench for the protection register and restart sequencer.
// Assumes a host model for register traffic and a ramp engine made here.
module protection_config_restart_test
    import pcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RETRY = 50;

    logic                  clock;
    logic                  reset_n;
    logic                  cfg_we;
    logic [7:0]            cfg_wdata;
    logic                  status_clr;
    logic [PCR_NFAULT-1:0] status_clr_mask;
    logic                  turn_on;
    logic [PCR_NFAULT-1:0] fault_in;
    logic                  ramp_done;
    logic                  ramp_hold;
    logic [7:0]            cfg;
    logic [PCR_NFAULT-1:0] status;
    logic                  oe, rup, rdn, hs_off, ls_on, retry;
    int                    bad_count, checks_done, cycles;
    logic                  found;
    logic                  pulsed;

    pcr_host_model i_host (.clock(clock), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
        .status_clr(status_clr), .status_clr_mask(status_clr_mask));

    pcr_protect #(.RETRY_CYC(RETRY)) i_dut (.clock(clock), .reset_n(reset_n),
        .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .status_clr(status_clr),
        .status_clr_mask(status_clr_mask), .turn_on(turn_on), .fault_in(fault_in),
        .ramp_done(ramp_done), .protection_config(cfg), .fault_status_register(status),
        .output_enable(oe), .ramp_up(rup), .ramp_down(rdn), .high_side_off(hs_off),
        .low_side_on(ls_on), .retry_pulse(retry));

    // --------------------------------------------------------------
    // Clock, ramp engine and hang guard
    // --------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // A ramp finishes one cycle after it starts unless held for a test.
    always @(posedge clock)
        ramp_done <= (rup | rdn) & ~ramp_hold & ~ramp_done;

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            final_report();
        end
    end

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Watches for a ramp-up start and a restart pulse within n cycles.
    task automatic wait_ramp(input int n);
        found = 1'b0;
        pulsed = 1'b0;
        repeat (n)
        begin
            @(posedge clock);
            #1;
            if (rup === 1'b1)
                found = 1'b1;
            if (retry === 1'b1)
                pulsed = 1'b1;
        end
    endtask

    task automatic trip(input int idx);
        @(posedge clock);
        fault_in[idx] <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic drop_faults();
        @(posedge clock);
        fault_in <= '0;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial
    begin
        reset_n = 1'b0;
        turn_on = 1'b0;
        fault_in = '0;
        ramp_hold = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check(cfg, 8'h43, "config reset");
        check({2'h0, status}, 8'h3f, "status reset");
        check({7'h0, hs_off}, 8'h01, "high side off in reset");
        reset_n <= 1'b1;
        foreach (i_dut.cfg_wdata[b])
        begin
            i_host.write_cfg(8'h01 << b);
            #1;
            check(cfg, 8'h01 << b, "config write");
        end
        $display("test register done");

        // Tracking disabled: a tracking error during ramp-up is ignored.
        i_host.write_cfg(8'h00);
        ramp_hold <= 1'b1;
        turn_on <= 1'b1;
        trip(PCR_F_TR);
        check({2'h0, status}, 8'h3f, "tracking ignored");
        drop_faults();
        ramp_hold <= 1'b0;
        repeat (4) @(posedge clock);
        $display("test tracking done");

        // Non-latching overcurrent retries only once the fault is gone.
        trip(PCR_F_OC);
        check({2'h0, status}, 8'h37, "oc status");
        check({7'h0, hs_off}, 8'h01, "oc fast off");
        check({7'h0, oe}, 8'h00, "oc output off");
        wait_ramp(2 * RETRY);
        check({7'h0, found}, 8'h00, "retry while fault");
        check({7'h0, pulsed}, 8'h00, "no retry pulse while fault");
        drop_faults();
        wait_ramp(RETRY + 10);
        check({7'h0, found}, 8'h01, "retry after fault");
        check({7'h0, pulsed}, 8'h01, "retry pulse after fault");
        repeat (4) @(posedge clock);
        // The tripped bit stays low until the host clears it.
        i_host.clear_status(6'h08);
        #1;
        check({2'h0, status}, 8'h3f, "oc status cleared");
        $display("test non latching done");

        // Latching overvoltage needs the host to clear the status bit.
        i_host.write_cfg(8'h43);
        trip(PCR_F_OV);
        check({6'h0, hs_off, ls_on}, 8'h03, "ov crowbar");
        check({2'h0, status}, 8'h3d, "ov status");
        drop_faults();
        wait_ramp(2 * RETRY);
        check({7'h0, found}, 8'h00, "latched stays off");
        i_host.clear_status(6'h02);
        wait_ramp(RETRY);
        check({7'h0, found}, 8'h01, "restart after clear");
        check({7'h0, pulsed}, 8'h01, "restart pulse after clear");
        repeat (4) @(posedge clock);
        $display("test latching done");

        // Latching undervoltage ramps down and is released by the turn-on command.
        i_host.write_cfg(8'h04);
        trip(PCR_F_UV);
        check({7'h0, rdn}, 8'h01, "uv soft off");
        check({7'h0, oe}, 8'h01, "uv output held for ramp");
        check({2'h0, status}, 8'h3b, "uv status");
        drop_faults();
        wait_ramp(2 * RETRY);
        check({7'h0, found}, 8'h00, "uv latched");
        turn_on <= 1'b0;
        repeat (3) @(posedge clock);
        turn_on <= 1'b1;
        wait_ramp(RETRY + 10);
        check({7'h0, found}, 8'h01, "restart after toggle");
        $display("test toggle done");

        // Cycling power through reset also clears a latched shutdown.
        trip(PCR_F_UV);
        drop_faults();
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check(cfg, 8'h43, "config after power cycle");
        check({2'h0, status}, 8'h3f, "status after power cycle");
        check({7'h0, hs_off}, 8'h01, "high side off in power cycle");
        @(posedge clock);
        reset_n <= 1'b1;
        wait_ramp(10);
        check({7'h0, found}, 8'h01, "restart after power cycle");
        $display("test power cycle done");
        final_report();
    end
endmodule // protection_config_restart_test
